// [src/ldc_avg.sv]
// module: sixteen-sample readback averager with error window check
`timescale 1ns/1ps
module ldc_avg (
	input wire logic mclk,
	input wire logic resetn,
	ldc_rb_if.avger rb
);
	import ldc_pkg::*;

	typedef struct packed {
		logic [SUM_W-1:0] sum;
		logic [3:0] cnt;
		logic [SAMPLE_W-1:0] avg;
		logic avg_valid;
		logic err;
	} ldc_avg_t;

	ldc_avg_t r;
	ldc_avg_t next_r;
	logic [SUM_W-1:0] total;
	logic [SAMPLE_W-1:0] mean;
	logic [SAMPLE_W+1:0] hi;
	logic [SAMPLE_W+1:0] lo_sum;

	assign total = r.sum + {{(SUM_W-SAMPLE_W){1'b0}}, rb.sample};
	assign mean = total[SUM_W-1:AVG_SHIFT];
	assign hi = {2'b00, rb.expected} + {6'h00, rb.window};
	assign lo_sum = {2'b00, mean} + {6'h00, rb.window};

	always_comb begin
		next_r = r;
		next_r.avg_valid = 1'b0;
		if (rb.sample_valid) begin
			next_r.cnt = r.cnt + 4'h1;
			next_r.sum = total;
			if (r.cnt == AVG_LAST) begin
				// sixteen samples done: mean published
				next_r.sum = '0;
				next_r.avg = mean;
				next_r.avg_valid = 1'b1;
				// outside expected plus or minus window
				next_r.err = ({2'b00, mean} > hi) || (lo_sum < {2'b00, rb.expected});
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign rb.avg = r.avg;
	assign rb.avg_valid = r.avg_valid;
	assign rb.err = r.err;

	AST_AVG_SIXTEEN: assert property (@(posedge mclk) disable iff (!resetn)
		rb.avg_valid |-> $past(r.cnt) == AVG_LAST && $past(rb.sample_valid))
		else $error("average published without sixteen samples");
endmodule // ldc_avg

// [src/ldc_ctrl.sv]
// module: limit dac selection, settings, readback check and two-step dwell cutting
// Behaviour
// - output off in current mode: voltage limit from off-state byte when selected, default 0
// - output on in voltage mode: current limit uses on-state byte if bit 7 set
// - output on in current mode: voltage limit uses on-state byte if bit 7 set
// - selector resets to 0; then both limits are zero while output is off
// - selector bit 0, voltage mode, output off: voltage limit at maximum
// - selector bit 1, current mode, output off: current limit at maximum
// - output off: bit 2 uses off voltage byte, bit 3 off current byte
// - maximum overrides user value when both chosen for one channel, in the mode where that maximum applies
// - security clear command returns the selector to 0
// - save command writes the system-set variables to nonvolatile memory
// - error window defaults to 32, accepts only 16 through 64
// - window query returns two ascii hex characters
// - each readback is the mean of sixteen consecutive samples
// - readback error when averaged value leaves expected plus or minus window
// - two-step dwell over limit is cut, then zero-volt step for the excess
// - limit query returns the single byte held for that parameter
// - output off in voltage mode: current limit from off-state byte (reset 128) when selected, default 0
`timescale 1ns/1ps
module ldc_ctrl #(
	parameter int TICK_CYCLES = ldc_pkg::HALF_MS_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire ldc_pkg::ldc_cmd_t cmd_code,
	input wire logic [7:0] cmd_data,
	output logic cmd_error,
	input wire logic qry_valid,
	input wire ldc_pkg::ldc_cmd_t qry_code,
	output logic qry_ack,
	output logic [15:0] qry_data,
	input wire logic output_on,
	input wire logic current_mode,
	input wire logic [7:0] vset_dac,
	input wire logic [7:0] iset_dac,
	output logic [7:0] vlim_dac,
	output logic [7:0] ilim_dac,
	input wire logic sample_valid,
	input wire logic [ldc_pkg::SAMPLE_W-1:0] sample,
	input wire logic [ldc_pkg::SAMPLE_W-1:0] expected,
	output logic [ldc_pkg::SAMPLE_W-1:0] rb_avg,
	output logic rb_avg_valid,
	output logic rb_error,
	input wire logic list_start,
	input wire logic list_two_step,
	input wire logic [15:0] list_dwell,
	output logic step_lead,
	output logic step_zero,
	output logic step_done,
	output logic nvm_wr_valid,
	output logic [7:0] nvm_wr_data
);
	import ldc_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LEAD = 3'b010,
		ST_ZERO = 3'b100
	} ldc_dwell_t;

	typedef struct packed {
		logic [7:0] off_vlim;
		logic [7:0] off_ilim;
		logic [7:0] on_ilim;
		logic [7:0] on_vlim;
		logic [3:0] sel;
		logic [7:0] ierr;
		logic [7:0] verr;
		logic [7:0] win;
		logic [7:0] lead;
		logic [7:0] sys_set;
		logic [7:0] vlim;
		logic [7:0] ilim;
		logic [15:0] qdata;
		logic qack;
		logic cerr;
		logic nvm_valid;
		logic [7:0] nvm_data;
		ldc_dwell_t dst;
		logic [15:0] rem;
		logic [15:0] excess;
		logic done;
		logic [15:0] tick_cnt;
		logic tick;
	} ldc_state_t;

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	ldc_state_t r;
	ldc_state_t next_r;
	logic [15:0] lead_w;

	assign lead_w = {8'h00, r.lead};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.qack = 1'b0;
		next_r.cerr = 1'b0;
		next_r.nvm_valid = 1'b0;
		next_r.done = 1'b0;

		// half-millisecond enable for dwell timing
		next_r.tick = 1'b0;
		next_r.tick_cnt = r.tick_cnt + 16'h0001;
		if (r.tick_cnt == TICK_LAST) begin
			next_r.tick_cnt = '0;
			next_r.tick = 1'b1;
		end

		// settings written by host commands
		if (cmd_valid) begin
			case (cmd_code)
				CMD_OFF_VLIM: next_r.off_vlim = cmd_data;
				CMD_OFF_ILIM: next_r.off_ilim = cmd_data;
				CMD_ON_ILIM: next_r.on_ilim = cmd_data;
				CMD_ON_VLIM: next_r.on_vlim = cmd_data;
				CMD_SELECT: next_r.sel = cmd_data[3:0];
				CMD_IERR: next_r.ierr = cmd_data;
				CMD_VERR: next_r.verr = cmd_data;
				CMD_WINDOW: begin
					// out-of-range window leaves the old value in place
					if (cmd_data >= WIN_MIN && cmd_data <= WIN_MAX) begin
						next_r.win = cmd_data;
					end else begin
						next_r.cerr = 1'b1;
					end
				end
				CMD_LEADING: next_r.lead = cmd_data;
				CMD_SAVE: begin
					next_r.nvm_valid = 1'b1;
					next_r.nvm_data = r.sys_set;
				end
				CMD_SEC_CLR: next_r.sel = RST_SELECT;
				CMD_SYS_SET: next_r.sys_set = cmd_data;
				default: next_r.cerr = 1'b1;
			endcase
		end

		// queries answer from the registered settings
		if (qry_valid) begin
			next_r.qack = 1'b1;
			case (qry_code)
				CMD_OFF_VLIM: next_r.qdata = {8'h00, r.off_vlim};
				CMD_OFF_ILIM: next_r.qdata = {8'h00, r.off_ilim};
				CMD_ON_ILIM: next_r.qdata = {8'h00, r.on_ilim};
				CMD_ON_VLIM: next_r.qdata = {8'h00, r.on_vlim};
				CMD_SELECT: next_r.qdata = {8'h00, ldc_hex_char(r.sel)};
				CMD_IERR: next_r.qdata = {8'h00, r.ierr};
				CMD_VERR: next_r.qdata = {8'h00, r.verr};
				CMD_WINDOW: next_r.qdata = {ldc_hex_char(r.win[7:4]), ldc_hex_char(r.win[3:0])};
				CMD_LEADING: next_r.qdata = {ldc_hex_char(r.lead[7:4]), ldc_hex_char(r.lead[3:0])};
				CMD_SYS_SET: next_r.qdata = {8'h00, r.sys_set};
				default: begin
					next_r.qdata = '0;
					next_r.cerr = 1'b1;
				end
			endcase
		end

		// limit dac selection; maximum is tested first so it wins in its own mode (voltage mode for vlim, current mode for ilim)
		if (!output_on) begin
			if (r.sel[SEL_V_MAX] && !current_mode) begin
				next_r.vlim = DAC_MAX;
			end else if (r.sel[SEL_V_USER]) begin
				next_r.vlim = r.off_vlim;
			end else begin
				next_r.vlim = DAC_ZERO;
			end
			if (r.sel[SEL_I_MAX] && current_mode) begin
				next_r.ilim = DAC_MAX;
			end else if (r.sel[SEL_I_USER]) begin
				next_r.ilim = r.off_ilim;
			end else begin
				next_r.ilim = DAC_ZERO;
			end
		end else begin
			next_r.vlim = vset_dac;
			next_r.ilim = iset_dac;
			if (current_mode && r.verr[ERR_FIXED_LIMIT]) begin
				next_r.vlim = r.on_vlim;
			end
			if (!current_mode && r.ierr[ERR_FIXED_LIMIT]) begin
				next_r.ilim = r.on_ilim;
			end
		end

		// two-step dwell: leading part capped, excess spent at zero volts
		case (r.dst)
			ST_IDLE: begin
				if (list_start) begin
					next_r.dst = ST_LEAD;
					next_r.rem = list_dwell;
					next_r.excess = '0;
					if (list_two_step && list_dwell > lead_w) begin
						next_r.rem = lead_w;
						next_r.excess = list_dwell - lead_w;
					end
				end
			end
			ST_LEAD: begin
				if (r.rem == '0) begin
					if (r.excess != '0) begin
						next_r.dst = ST_ZERO;
						next_r.rem = r.excess;
					end else begin
						next_r.dst = ST_IDLE;
						next_r.done = 1'b1;
					end
				end else if (r.tick) begin
					next_r.rem = r.rem - 16'h0001;
				end
			end
			ST_ZERO: begin
				if (r.rem == '0) begin
					next_r.dst = ST_IDLE;
					next_r.excess = '0;
					next_r.done = 1'b1;
				end else if (r.tick) begin
					next_r.rem = r.rem - 16'h0001;
				end
			end
			default: next_r.dst = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			r <= '0;
			r.off_vlim <= RST_OFF_VLIM;
			r.off_ilim <= RST_OFF_ILIM;
			r.on_ilim <= RST_ON_ILIM;
			r.on_vlim <= RST_ON_VLIM;
			r.sel <= RST_SELECT;
			r.ierr <= RST_ERR_CTRL;
			r.verr <= RST_ERR_CTRL;
			r.win <= RST_WINDOW;
			r.lead <= RST_LEADING;
			r.dst <= ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// readback averager
	// ------------------------------------------------------------
	ldc_rb_if rb ();
	assign rb.sample_valid = sample_valid;
	assign rb.sample = sample;
	assign rb.expected = expected;
	assign rb.window = r.win;

	ldc_avg u_avg (
		.mclk(mclk),
		.resetn(resetn),
		.rb(rb)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign cmd_error = r.cerr;
	assign qry_ack = r.qack;
	assign qry_data = r.qdata;
	assign vlim_dac = r.vlim;
	assign ilim_dac = r.ilim;
	assign rb_avg = rb.avg;
	assign rb_avg_valid = rb.avg_valid;
	assign rb_error = rb.err;
	assign step_lead = (r.dst == ST_LEAD);
	assign step_zero = (r.dst == ST_ZERO);
	assign step_done = r.done;
	assign nvm_wr_valid = r.nvm_valid;
	assign nvm_wr_data = r.nvm_data;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking ldc_cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence s_off_v;
		!output_on && !current_mode;
	endsequence
	sequence s_off_i;
		!output_on && current_mode;
	endsequence
	sequence s_cut_start;
		r.dst == ST_IDLE && list_start && list_two_step && list_dwell > lead_w;
	endsequence
	sequence s_lead_spent;
		r.dst == ST_LEAD && r.rem == '0 && r.excess != '0;
	endsequence

	AST_OFF_DEFAULT: assert property (!output_on && r.sel == RST_SELECT |=>
		vlim_dac == DAC_ZERO && ilim_dac == DAC_ZERO)
		else $error("off-state limits not zero with default selector");
	AST_V_MAX: assert property (s_off_v ##0 r.sel[SEL_V_MAX] |=> vlim_dac == DAC_MAX)
		else $error("voltage limit not at maximum");
	AST_I_MAX: assert property (s_off_i ##0 r.sel[SEL_I_MAX] |=> ilim_dac == DAC_MAX)
		else $error("current limit not at maximum");
	AST_V_USER: assert property (s_off_i ##0 r.sel[SEL_V_USER] |=> vlim_dac == $past(r.off_vlim))
		else $error("off voltage byte not applied");
	AST_I_USER: assert property (s_off_v ##0 r.sel[SEL_I_USER] |=> ilim_dac == $past(r.off_ilim))
		else $error("off current byte not applied");
	AST_ON_I: assert property (output_on && !current_mode && r.ierr[ERR_FIXED_LIMIT] |=>
		ilim_dac == $past(r.on_ilim))
		else $error("on current byte not applied");
	AST_ON_V: assert property (output_on && current_mode && r.verr[ERR_FIXED_LIMIT] |=>
		vlim_dac == $past(r.on_vlim))
		else $error("on voltage byte not applied");
	AST_SEC_CLR: assert property (cmd_valid && cmd_code == CMD_SEC_CLR ##1 !output_on |=>
		vlim_dac == DAC_ZERO && ilim_dac == DAC_ZERO)
		else $error("security clear left selector set");
	AST_WIN_RANGE: assert property (cmd_valid && cmd_code == CMD_WINDOW && (cmd_data < WIN_MIN ||
		cmd_data > WIN_MAX) |=> cmd_error && r.win == $past(r.win))
		else $error("window out of range not refused");
	AST_WIN_QRY: assert property (qry_valid && qry_code == CMD_WINDOW && !cmd_valid |=>
		qry_ack && qry_data == {ldc_hex_char(r.win[7:4]), ldc_hex_char(r.win[3:0])})
		else $error("window query wrong");
	AST_SAVE: assert property (cmd_valid && cmd_code == CMD_SAVE |=>
		nvm_wr_valid && nvm_wr_data == $past(r.sys_set))
		else $error("save did not write system settings");
	AST_CUT: assert property (s_cut_start |=> step_lead && r.rem == $past(lead_w) &&
		r.excess == $past(list_dwell) - $past(lead_w))
		else $error("long dwell not cut to leading limit");
	AST_ZERO_STEP: assert property (s_lead_spent |=> step_zero && r.rem == $past(r.excess))
		else $error("zero-volt step not inserted");
	AST_HOLD: assert property (!cmd_valid |=> r.on_vlim == $past(r.on_vlim) &&
		r.off_ilim == $past(r.off_ilim))
		else $error("limit byte changed without a write");
endmodule // ldc_ctrl

// [src/ldc_pkg.sv]
// package: constants, command codes and helpers for the limit dac controller
package ldc_pkg;
	// ------------------------------------------------------------
	// command and query codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_OFF_VLIM = 4'h0,
		CMD_OFF_ILIM = 4'h1,
		CMD_ON_ILIM = 4'h2,
		CMD_ON_VLIM = 4'h3,
		CMD_SELECT = 4'h4,
		CMD_IERR = 4'h5,
		CMD_VERR = 4'h6,
		CMD_WINDOW = 4'h7,
		CMD_LEADING = 4'h8,
		CMD_SAVE = 4'h9,
		CMD_SEC_CLR = 4'ha,
		CMD_SYS_SET = 4'hb
	} ldc_cmd_t;

	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] RST_OFF_VLIM = 8'h00;
	localparam logic [7:0] RST_OFF_ILIM = 8'h80;
	localparam logic [7:0] RST_ON_ILIM = 8'h80;
	localparam logic [7:0] RST_ON_VLIM = 8'h00;
	localparam logic [3:0] RST_SELECT = 4'h0;
	localparam logic [7:0] RST_ERR_CTRL = 8'h00;
	localparam logic [7:0] RST_WINDOW = 8'h20;
	localparam logic [7:0] RST_LEADING = 8'h50;
	localparam logic [7:0] WIN_MIN = 8'h10;
	localparam logic [7:0] WIN_MAX = 8'h40;
	localparam int SEL_V_MAX = 0;
	localparam int SEL_I_MAX = 1;
	localparam int SEL_V_USER = 2;
	localparam int SEL_I_USER = 3;
	localparam int ERR_FIXED_LIMIT = 7;
	localparam logic [7:0] DAC_MAX = 8'hff;
	localparam logic [7:0] DAC_ZERO = 8'h00;

	// ------------------------------------------------------------
	// readback and timing
	// ------------------------------------------------------------
	localparam int SAMPLE_W = 12;
	localparam int SUM_W = 16;
	localparam int AVG_SHIFT = 4;
	localparam logic [3:0] AVG_LAST = 4'hf;
	localparam int CLK_PERIOD_NS = 100;
	localparam int HALF_MS_NS = 500000;
	localparam int HALF_MS_CYC = HALF_MS_NS / CLK_PERIOD_NS;

	localparam logic [7:0] ASC_DIGIT = 8'h30;
	localparam logic [7:0] ASC_ALPHA = 8'h37;
	localparam logic [3:0] NIB_TEN = 4'ha;

	// one hex nibble as an ascii character
	function automatic logic [7:0] ldc_hex_char(input logic [3:0] n);
		ldc_hex_char = (n < NIB_TEN) ? (ASC_DIGIT + {4'h0, n}) : (ASC_ALPHA + {4'h0, n});
	endfunction
endpackage

// [src/ldc_rb_if.sv]
// interface: readback samples in, averaged result and window flag out
`timescale 1ns/1ps
interface ldc_rb_if;
	import ldc_pkg::*;
	logic sample_valid;
	logic [SAMPLE_W-1:0] sample;
	logic [SAMPLE_W-1:0] expected;
	logic [7:0] window;
	logic [SAMPLE_W-1:0] avg;
	logic avg_valid;
	logic err;
	modport ctrl (output sample_valid, sample, expected, window, input avg, avg_valid, err);
	modport avger (input sample_valid, sample, expected, window, output avg, avg_valid, err);
endinterface

// [test/ldc_ctrl_tb.sv]
// testbench for the limit dac controller
`timescale 1ns/1ps
module ldc_ctrl_tb;
	import ldc_pkg::*;
	localparam int TICK = 4;
	logic mclk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, qry_valid = 1'b0, cmd_error, qry_ack;
	ldc_cmd_t cmd_code = CMD_OFF_VLIM, qry_code = CMD_OFF_VLIM;
	logic [7:0] cmd_data = 8'h00, vset_dac = 8'h00, iset_dac = 8'h00, vlim_dac, ilim_dac, nvm_wr_data;
	logic [15:0] qry_data, list_dwell = 16'h0000;
	logic output_on = 1'b0, current_mode = 1'b0, sample_valid, rb_avg_valid, rb_error, go = 1'b0;
	logic [SAMPLE_W-1:0] sample, expected = '0, rb_avg;
	logic list_start = 1'b0, list_two_step = 1'b0, step_lead, step_zero, step_done, nvm_wr_valid;
	int n_errors = 0, comparisons = 0;
	ldc_cmd_t qc[9] = '{CMD_OFF_VLIM, CMD_OFF_ILIM, CMD_ON_ILIM, CMD_ON_VLIM, CMD_SELECT, CMD_IERR, CMD_VERR,
		CMD_WINDOW, CMD_LEADING};
	logic [15:0] qe[9] = '{16'h0000, 16'h0080, 16'h0080, 16'h0000, 16'h0030, 16'h0000, 16'h0000, 16'h3230,
		16'h3530};

	always #50 mclk = ~mclk;

	ldc_ctrl #(.TICK_CYCLES(TICK)) DUT (.mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_error(cmd_error), .qry_valid(qry_valid),
		.qry_code(qry_code), .qry_ack(qry_ack), .qry_data(qry_data), .output_on(output_on),
		.current_mode(current_mode), .vset_dac(vset_dac), .iset_dac(iset_dac), .vlim_dac(vlim_dac),
		.ilim_dac(ilim_dac), .sample_valid(sample_valid), .sample(sample), .expected(expected),
		.rb_avg(rb_avg), .rb_avg_valid(rb_avg_valid), .rb_error(rb_error), .list_start(list_start),
		.list_two_step(list_two_step), .list_dwell(list_dwell), .step_lead(step_lead),
		.step_zero(step_zero), .step_done(step_done), .nvm_wr_valid(nvm_wr_valid),
		.nvm_wr_data(nvm_wr_data));
	ldc_stage_model stage (.mclk(mclk), .resetn(resetn), .go(go), .vlim_dac(vlim_dac),
		.sample_valid(sample_valid), .sample(sample));

	// ------------------------------------------------------------
	// compare and report
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		chk({15'h0000, got}, {15'h0000, exp}, what);
	endtask
	task automatic hang(input string what);
		n_errors++;
		$display("wrong value at %0t: %s never came", $time, what);
		end_of_test();
	endtask

	// ------------------------------------------------------------
	// port access; every task starts and ends just after an edge
	// ------------------------------------------------------------
	task automatic cmd(input ldc_cmd_t c, input logic [7:0] d, input logic err);
		// one idle edge first, so a strobe never drops and rises in the same step
		@(posedge mclk);
		#1;
		cmd_code = c;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(posedge mclk); #1;
		cmd_valid = 1'b0;
		chk1(cmd_error, err, "command error");
	endtask
	task automatic qry(input ldc_cmd_t c, input logic [15:0] e);
		@(posedge mclk);
		#1;
		qry_code = c;
		qry_valid = 1'b1;
		@(posedge mclk); #1;
		qry_valid = 1'b0;
		chk1(qry_ack, 1'b1, "query ack");
		chk(qry_data, e, "query data");
	endtask
	task automatic dac(input logic [15:0] e);
		repeat (2) @(posedge mclk);
		#1;
		chk({vlim_dac, ilim_dac}, e, "limit dacs");
	endtask
	function automatic logic [15:0] off_exp(input logic [3:0] s, input logic cm);
		logic [7:0] v, i;
		v = (s[SEL_V_MAX] && !cm) ? DAC_MAX : (s[SEL_V_USER] ? 8'h5a : DAC_ZERO);
		i = (s[SEL_I_MAX] && cm) ? DAC_MAX : (s[SEL_I_USER] ? 8'h33 : DAC_ZERO);
		return {v, i};
	endfunction
	task automatic rb(input logic [11:0] ex, input logic err);
		int k;
		expected = ex;
		go = 1'b1;
		@(posedge mclk); #1;
		go = 1'b0;
		for (k = 0; k < 40 && rb_avg_valid !== 1'b1; k++) begin
			@(posedge mclk); #1;
		end
		if (k >= 40) hang("mean");
		chk({4'h0, rb_avg}, 16'h0407, "mean");
		chk1(rb_error, err, "readback error");
	endtask
	function automatic logic in_win(input int n, input int t);
		return (t == 0) ? (n == 0) : (n >= (t - 1) * TICK && n <= t * TICK + 2);
	endfunction
	task automatic dwell(input logic two, input logic [15:0] d, input int lt, input int zt);
		int k, nl, nz;
		list_two_step = two;
		list_dwell = d;
		list_start = 1'b1;
		@(posedge mclk); #1;
		list_start = 1'b0;
		nl = 0;
		nz = 0;
		for (k = 0; k < 500 && step_done !== 1'b1; k++) begin
			nl += (step_lead === 1'b1);
			nz += (step_zero === 1'b1);
			@(posedge mclk); #1;
		end
		if (k >= 500) hang("step end");
		chk1(in_win(nl, lt), 1'b1, "lead length");
		chk1(in_win(nz, zt), 1'b1, "zero step length");
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge mclk);
		#1;
		resetn = 1'b1;
		for (int k = 0; k < 9; k++) qry(qc[k], qe[k]);
		dac(16'h0000);
		$display("test defaults done");
		cmd(CMD_OFF_VLIM, 8'h5a, 1'b0);
		cmd(CMD_OFF_ILIM, 8'h33, 1'b0);
		qry(CMD_OFF_ILIM, 16'h0033);
		for (int s = 0; s < 16; s++) begin
			cmd(CMD_SELECT, 8'(s), 1'b0);
			qry(CMD_SELECT, {8'h00, (s < 10) ? 8'(8'h30 + s) : 8'(8'h37 + s)});
			for (int cm = 0; cm < 2; cm++) begin
				current_mode = cm[0];
				dac(off_exp(4'(s), cm[0]));
			end
		end
		$display("test off state done");
		cmd(CMD_SEC_CLR, 8'h00, 1'b0);
		qry(CMD_SELECT, 16'h0030);
		dac(16'h0000);
		$display("test security clear done");
		output_on = 1'b1;
		vset_dac = 8'h40;
		iset_dac = 8'h22;
		cmd(CMD_ON_ILIM, 8'h44, 1'b0);
		cmd(CMD_ON_VLIM, 8'h55, 1'b0);
		// bit 7 alone selects the fixed limit
		cmd(CMD_IERR, 8'h7f, 1'b0);
		cmd(CMD_VERR, 8'h7f, 1'b0);
		dac(16'h4022);
		current_mode = 1'b0;
		dac(16'h4022);
		cmd(CMD_IERR, 8'h80, 1'b0);
		cmd(CMD_VERR, 8'h80, 1'b0);
		qry(CMD_IERR, 16'h0080);
		qry(CMD_VERR, 16'h0080);
		dac(16'h4044);
		current_mode = 1'b1;
		dac(16'h5522);
		current_mode = 1'b0;
		$display("test output on done");
		cmd(CMD_WINDOW, 8'h0f, 1'b1);
		cmd(CMD_WINDOW, 8'h41, 1'b1);
		qry(CMD_WINDOW, 16'h3230);
		cmd(CMD_WINDOW, 8'h40, 1'b0);
		qry(CMD_WINDOW, 16'h3430);
		cmd(CMD_WINDOW, 8'h10, 1'b0);
		qry(CMD_WINDOW, 16'h3130);
		cmd(ldc_cmd_t'(4'hc), 8'h00, 1'b1);
		qry(ldc_cmd_t'(4'hd), 16'h0000);
		chk1(cmd_error, 1'b1, "query refused");
		$display("test window done");
		cmd(CMD_SYS_SET, 8'ha7, 1'b0);
		chk1(nvm_wr_valid, 1'b0, "store early");
		qry(CMD_SYS_SET, 16'h00a7);
		cmd(CMD_SAVE, 8'h00, 1'b0);
		chk1(nvm_wr_valid, 1'b1, "store strobe");
		chk({8'h00, nvm_wr_data}, 16'h00a7, "store data");
		$display("test save done");
		// mean of the ramp on a 0x40 dac is 0x407, window 16
		rb(12'h417, 1'b0);
		rb(12'h418, 1'b1);
		rb(12'h3f7, 1'b0);
		rb(12'h3f6, 1'b1);
		$display("test readback done");
		cmd(CMD_LEADING, 8'h02, 1'b0);
		qry(CMD_LEADING, 16'h3032);
		dwell(1'b1, 16'h0005, 2, 3);
		dwell(1'b1, 16'h0002, 2, 0);
		dwell(1'b0, 16'h0005, 5, 0);
		$display("test dwell done");
		end_of_test();
	end
endmodule // ldc_ctrl_tb

// [test/ldc_stage_model.sv]
// output stage model: turns the voltage limit dac into bursts of readback samples
`timescale 1ns/1ps
module ldc_stage_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic go,
	input wire logic [7:0] vlim_dac,
	output logic sample_valid,
	output logic [ldc_pkg::SAMPLE_W-1:0] sample
);
	import ldc_pkg::*;
	// ------------------------------------------------------------
	// sample burst
	// ------------------------------------------------------------
	logic [4:0] left;
	logic go_s;
	initial begin
		left = 5'h00;
		sample_valid = 1'b0;
		sample = '0;
	end
	always @(posedge mclk) begin
		go_s = go;
		#1;
		if (!resetn) begin
			left = 5'h00;
			sample_valid = 1'b0;
		end else if (left != 5'h00) begin
			// ramp of 0..15 on top of the dac level, so the mean is level plus 7
			sample_valid = 1'b1;
			sample = {vlim_dac, 4'h0} + {7'h00, 5'h10 - left};
			left = left - 5'h01;
		end else begin
			sample_valid = 1'b0;
			// idle bus shows no stale sample
			sample = ~sample;
			if (go_s) begin
				left = 5'h10;
			end
		end
	end
endmodule // ldc_stage_model
